// >>> src/block_transfer_load_store_unit.sv
`timescale 1ns/1ps
// Summary of operation
// [RULE_01] Address low two bits reach memory unchanged
// [RULE_02] User-bank load with pc restores status
// [RULE_03] User-bank store with pc reads user bank
// [RULE_04] User-bank without pc moves user registers
// [RULE_05] Software avoids write-back on user-bank transfers
// [RULE_06] No banked read right after user load
// [RULE_07] User-bank flag only in privileged modes
// [RULE_08] Program counter never serves as base
// [RULE_09] Base written back end of second cycle
// [RULE_10] Base stored first old, later updated
// [RULE_11] Loaded base overrides written-back base
// [RULE_12] Memory manager may fault any transfer
// [RULE_13] Store abort finishes, then traps
// [RULE_14] Memory manager blocks writes after fault
// [RULE_15] Load abort stops register writes, skips
// [RULE_16] Aborted load restores base value
// [RULE_17] Abort trap only after load completes
// [RULE_18] Load cycle counts nS+1N+1I, pc adds
// [RULE_19] Store takes (n-1)S plus 2N
// [RULE_20] Pre-index and up bits choose mode
// [RULE_21] Stack modes map onto same bits
// [RULE_22] Assembler suffixes set write-back, user flags
// [RULE_23] Ascending register order, pc last
// [RULE_24] Stored pc equals instruction address plus twelve
// [RULE_25] Consecutive word addresses step by four
module block_transfer_load_store_unit (
  input  wire logic                         mclk,
  input  wire logic                         reset,
  input  wire logic                         start,
  input  wire logic                         is_load,
  input  wire logic                         pre_index,
  input  wire logic                         up_dir,
  input  wire logic                         user_bank_flag,
  input  wire logic                         writeback_flag,
  input  wire logic [lsm_pkg::IDX_W-1:0]    base_idx,
  input  wire logic [lsm_pkg::REG_COUNT-1:0] reg_list,
  input  wire logic [lsm_pkg::DATA_W-1:0]   base_value,
  input  wire logic [lsm_pkg::DATA_W-1:0]   instr_addr,
  input  wire logic [lsm_pkg::DATA_W-1:0]   rd_data,
  input  wire logic [lsm_pkg::DATA_W-1:0]   mem_rdata,
  input  wire logic                         memory_fault_flag,
  input  wire logic                         reg_wr_ready,
  output logic                              busy,
  output logic                              mem_req,
  output logic                              mem_write,
  output logic [lsm_pkg::DATA_W-1:0]        mem_addr,
  output logic [lsm_pkg::DATA_W-1:0]        mem_wdata,
  output lsm_pkg::cycle_kind_t              cycle_kind,
  output logic [lsm_pkg::IDX_W-1:0]         rd_idx,
  output logic                              rd_user,
  output logic                              base_wr,
  output logic [lsm_pkg::IDX_W-1:0]         base_wr_idx,
  output logic [lsm_pkg::DATA_W-1:0]        base_wr_data,
  output logic                              reg_wr_valid,
  output logic [lsm_pkg::IDX_W-1:0]         reg_wr_idx,
  output logic                              reg_wr_user,
  output logic [lsm_pkg::DATA_W-1:0]        reg_wr_data,
  output logic                              status_restore,
  output logic                              data_abort
);
  import lsm_pkg::*;

  // ********************************************************************
  // State
  // ********************************************************************
  typedef struct packed {
    phase_t             st;
    logic               load;
    logic               user_bank;
    logic               pc_in;
    logic               wb;
    logic               base_in;
    logic [IDX_W-1:0]   base_idx;
    logic [15:0]        remain;
    logic [31:0]        addr;
    logic [31:0]        orig_base;
    logic [31:0]        new_base;
    logic [31:0]        pc_val;
    logic [CNT_W-1:0]   issued;
    logic [CNT_W-1:0]   words;
    logic [1:0]         cyc;
    logic [1:0]         tail;
    logic               stalled;
    logic               stall_seen;
    logic               dp_valid;
    logic               dp_first;
    logic [IDX_W-1:0]   dp_idx;
    logic               aborted;
    logic [CNT_W-1:0]   cnt_n;
    logic [CNT_W-1:0]   cnt_s;
    logic [CNT_W-1:0]   cnt_i;
    logic               busy;
    logic               mem_req;
    logic               mem_write;
    logic [31:0]        mem_addr;
    logic [31:0]        mem_wdata;
    cycle_kind_t        kind;
    logic [IDX_W-1:0]   rd_idx;
    logic               rd_user;
    logic               base_wr;
    logic [31:0]        base_wr_data;
    logic               wr_valid;
    logic [IDX_W-1:0]   wr_idx;
    logic               wr_user;
    logic [31:0]        wr_data;
    logic               status_restore;
    logic               data_abort;
  } state_t;

  state_t                 q;
  state_t                 n;
  logic                   fifo_push;
  logic [ENTRY_W-1:0]     fifo_in;
  logic                   fifo_in_ready;
  logic                   fifo_out_valid;
  logic                   fifo_pop;
  logic [ENTRY_W-1:0]     fifo_out;
  logic [3:0]             fifo_count;
  logic [31:0]            span;
  logic [IDX_W-1:0]       nidx;

  function automatic logic [CNT_W-1:0] popcount(input logic [15:0] v);
    logic [CNT_W-1:0] c;
    c = '0;
    for (int i = 0; i < REG_COUNT; i++) begin
      c = c + CNT_W'(v[i]);
    end
    return c;
  endfunction

  function automatic logic [IDX_W-1:0] lowest_set(input logic [15:0] v);
    logic [IDX_W-1:0] r;
    r = '0;
    for (int i = REG_COUNT - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = IDX_W'(i);
      end
    end
    return r;
  endfunction

  // ********************************************************************
  // Load data buffer
  // ********************************************************************
  assign fifo_pop = !q.wr_valid || reg_wr_ready;

  lsm_fifo #(
    .WIDTH (ENTRY_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .reset     (reset),
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out),
    .count     (fifo_count)
  );

  // ********************************************************************
  // Next state
  // ********************************************************************
  always_comb begin
    n              = q;
    fifo_push      = 1'b0;
    fifo_in        = '0;
    nidx           = '0;
    span           = 32'(popcount(reg_list)) * WORD_STEP;
    n.base_wr      = 1'b0;
    n.data_abort   = 1'b0;
    n.mem_req      = 1'b0;
    n.kind         = CYC_IDLE;
    n.dp_valid     = q.mem_req;
    n.dp_idx       = q.rd_idx;
    if (q.busy) begin
      unique case (q.kind)
        CYC_N:    n.cnt_n = q.cnt_n + CNT_W'(1);
        CYC_S:    n.cnt_s = q.cnt_s + CNT_W'(1);
        CYC_I:    n.cnt_i = q.cnt_i + CNT_W'(1);
        CYC_IDLE: n.cnt_i = q.cnt_i;
      endcase
      if (q.cyc != CYC_SAT) begin
        n.cyc = q.cyc + 2'(1);
      end
    end
    // [RULE_09] Second-cycle write-back
    if (q.busy && q.cyc == CYC_FIRST) begin
      n.base_wr = q.wb;
    end
    // Register write port, fed from the buffer
    if (q.wr_valid && reg_wr_ready) begin
      n.wr_valid       = 1'b0;
      n.status_restore = 1'b0;
    end
    if (fifo_pop && fifo_out_valid) begin
      n.wr_valid = 1'b1;
      n.wr_idx   = fifo_out[ENTRY_W-1:DATA_W];
      n.wr_data  = fifo_out[DATA_W-1:0];
      // [RULE_04] User bank without pc
      n.wr_user  = q.user_bank && !q.pc_in;
      // [RULE_02] Status restore with pc
      n.status_restore = q.user_bank && q.pc_in && (fifo_out[ENTRY_W-1:DATA_W] == PC_IDX);
    end
    // Data phase of the previous address cycle
    if (q.dp_valid) begin
      if (memory_fault_flag) begin
        // [RULE_13] Note fault, keep running
        n.aborted = 1'b1;
      end else if (q.load && !q.aborted) begin
        // [RULE_15] Writes stop at first fault
        fifo_push = 1'b1;
        fifo_in   = {q.dp_idx, mem_rdata};
      end
    end
    // Store data read in the address phase, out in the data phase
    if (q.mem_req && !q.load) begin
      // [RULE_24] Stored pc value
      if (q.rd_idx == PC_IDX) begin
        n.mem_wdata = q.pc_val;
      // [RULE_10] Base second or later
      end else if (q.rd_idx == q.base_idx && !q.dp_first && q.wb) begin
        n.mem_wdata = q.new_base;
      end else begin
        n.mem_wdata = rd_data;
      end
    end
    unique case (q.st)
      ST_IDLE: begin
        if (start) begin
          n.st         = ST_XFER;
          n.busy       = 1'b1;
          n.load       = is_load;
          n.user_bank  = user_bank_flag;
          n.pc_in      = reg_list[PC_IDX];
          n.wb         = writeback_flag;
          n.base_idx   = base_idx;
          n.base_in    = reg_list[base_idx];
          n.remain     = reg_list;
          n.words      = popcount(reg_list);
          n.orig_base  = base_value;
          n.pc_val     = instr_addr + PC_STORE_OFFSET;
          n.issued     = '0;
          n.cyc        = CYC_FIRST;
          n.stalled    = 1'b1;
          n.stall_seen = 1'b0;
          n.aborted    = 1'b0;
          n.cnt_n      = '0;
          n.cnt_s      = '0;
          n.cnt_i      = '0;
          // [RULE_20] [RULE_21] Start address from pre-index and up bits
          if (up_dir) begin
            n.new_base = base_value + span;
            n.addr     = pre_index ? base_value + WORD_STEP : base_value;
          end else begin
            n.new_base = base_value - span;
            n.addr     = pre_index ? base_value - span : base_value - span + WORD_STEP;
          end
          n.base_wr_data = n.new_base;
        end
      end
      ST_XFER: begin
        n.st = ST_XFER;
      end
      ST_INTERNAL: begin
        n.st   = ST_TAIL;
        n.tail = !q.load ? 2'h0 : (q.pc_in ? TAIL_LEN_PC : TAIL_LEN_SHORT);
        n.kind = q.load ? CYC_I : CYC_N;
      end
      ST_TAIL: begin
        // [RULE_16] Restore base after abort
        if (q.load && q.kind == CYC_I && n.aborted && q.base_in) begin
          fifo_push = 1'b1;
          fifo_in   = {q.base_idx, q.wb ? q.new_base : q.orig_base};
        end
        n.tail = q.tail - 2'(1);
        n.kind = (q.tail == TAIL_LEN_PC) ? CYC_N : CYC_S;
        if (q.tail == 2'h0) begin
          n.tail = 2'h0;
          n.kind = CYC_IDLE;
          if (q.load) begin
            n.st = ST_DRAIN;
          end else begin
            n.st         = ST_IDLE;
            n.busy       = 1'b0;
            // [RULE_13] Trap after store completes
            n.data_abort = n.aborted;
          end
        end
      end
      ST_DRAIN: begin
        if (fifo_count == '0 && !n.wr_valid) begin
          n.st         = ST_IDLE;
          n.busy       = 1'b0;
          // [RULE_17] Trap after load completes
          n.data_abort = n.aborted;
        end
      end
      default: begin
        n.st   = ST_IDLE;
        n.busy = 1'b0;
      end
    endcase
    // Address issue, one word per cycle; loads issue only while the buffer has room
    if (n.st == ST_XFER) begin
      if (!n.load || (int'(fifo_count) + int'(fifo_push) + int'(q.mem_req) < FIFO_DEPTH)) begin
        // [RULE_23] Lowest register first
        nidx             = lowest_set(n.remain);
        n.remain[nidx]   = 1'b0;
        n.mem_req        = 1'b1;
        n.mem_write      = !n.load;
        n.mem_addr       = n.addr;
        // [RULE_25] Next word address
        n.addr           = n.addr + WORD_STEP;
        n.rd_idx         = nidx;
        // [RULE_03] [RULE_04] Bank choice for reads
        n.rd_user        = n.user_bank && !(n.load && n.pc_in);
        n.dp_first       = (n.issued == '0);
        n.issued         = n.issued + CNT_W'(1);
        n.kind           = n.stalled ? CYC_N : CYC_S;
        n.stalled        = 1'b0;
        if (n.remain == '0) begin
          // [RULE_18] [RULE_19] Closing cycles
          n.st   = ST_INTERNAL;
        end
      end else begin
        n.stalled    = 1'b1;
        n.stall_seen = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  // ********************************************************************
  // Outputs
  // ********************************************************************
  assign busy           = q.busy;
  assign mem_req        = q.mem_req;
  assign mem_write      = q.mem_write;
  assign mem_addr       = q.mem_addr;
  assign mem_wdata      = q.mem_wdata;
  assign cycle_kind     = q.kind;
  assign rd_idx         = q.rd_idx;
  assign rd_user        = q.rd_user;
  assign base_wr        = q.base_wr;
  assign base_wr_idx    = q.base_idx;
  assign base_wr_data   = q.base_wr_data;
  assign reg_wr_valid   = q.wr_valid;
  assign reg_wr_idx     = q.wr_idx;
  assign reg_wr_user    = q.wr_user;
  assign reg_wr_data    = q.wr_data;
  assign status_restore = q.status_restore;
  assign data_abort     = q.data_abort;

  // ********************************************************************
  // Checks
  // ********************************************************************
  sequence s_begin;
    q.st == ST_IDLE && start;
  endsequence
  sequence s_wb_pulse;
    !base_wr ##1 !base_wr ##1 base_wr ##1 !base_wr;
  endsequence

  property p_low_bits;
    @(posedge mclk) disable iff (reset)
      mem_req |-> (mem_addr[1:0] & ALIGN_MASK) == q.orig_base[1:0];
  endproperty
  a_low_bits: assert property (p_low_bits) else $error("address low bits altered"); // [RULE_01]

  property p_status_pc;
    @(posedge mclk) disable iff (reset)
      status_restore |-> reg_wr_valid && reg_wr_idx == PC_IDX && q.user_bank;
  endproperty
  a_status_pc: assert property (p_status_pc) else $error("status restore without pc"); // [RULE_02]

  property p_store_user;
    @(posedge mclk) disable iff (reset)
      mem_req && mem_write && q.user_bank |-> rd_user;
  endproperty
  a_store_user: assert property (p_store_user) else $error("store not from user bank"); // [RULE_03]

  property p_load_user;
    @(posedge mclk) disable iff (reset)
      reg_wr_valid && q.load && q.user_bank && !q.pc_in |-> reg_wr_user;
  endproperty
  a_load_user: assert property (p_load_user) else $error("load not to user bank"); // [RULE_04]

  property p_wb_time;
    @(posedge mclk) disable iff (reset)
      s_begin and writeback_flag |-> s_wb_pulse;
  endproperty
  a_wb_time: assert property (p_wb_time) else $error("write-back not in second cycle"); // [RULE_09]

  property p_base_later;
    @(posedge mclk) disable iff (reset)
      mem_req && mem_write && rd_idx == q.base_idx && rd_idx != PC_IDX && q.issued > 1 && q.wb
        |=> mem_wdata == q.new_base;
  endproperty
  a_base_later: assert property (p_base_later) else $error("later base not updated"); // [RULE_10]

  property p_pc_store;
    @(posedge mclk) disable iff (reset)
      mem_req && mem_write && rd_idx == PC_IDX |=> mem_wdata == $past(instr_addr) + 32'h0000_000c;
  endproperty
  a_pc_store: assert property (p_pc_store) else $error("stored pc value wrong"); // [RULE_24]

  property p_abort_skip;
    @(posedge mclk) disable iff (reset)
      q.dp_valid && q.load && memory_fault_flag ##1 q.aborted [*1] |-> !(fifo_push && q.st == ST_XFER);
  endproperty
  a_abort_skip: assert property (p_abort_skip) else $error("load written after fault"); // [RULE_15]

  property p_abort_end;
    @(posedge mclk) disable iff (reset)
      data_abort |-> !busy && $past(busy) && $past(q.aborted);
  endproperty
  a_abort_end: assert property (p_abort_end) else $error("abort trap before completion"); // [RULE_17]

  property p_store_cycles;
    @(posedge mclk) disable iff (reset)
      $fell(busy) && !q.load && !q.stall_seen |-> q.cnt_n == 5'h2 && q.cnt_s == q.words - 5'h1;
  endproperty
  a_store_cycles: assert property (p_store_cycles) else $error("store cycle count wrong"); // [RULE_19]

  property p_load_cycles;
    @(posedge mclk) disable iff (reset)
      $fell(busy) && q.load && !q.stall_seen |-> q.cnt_i == 5'h1
        && q.cnt_n == (q.pc_in ? 5'h2 : 5'h1) && q.cnt_s == q.words + (q.pc_in ? 5'h1 : 5'h0);
  endproperty
  a_load_cycles: assert property (p_load_cycles) else $error("load cycle count wrong"); // [RULE_18]

  property p_step;
    @(posedge mclk) disable iff (reset)
      mem_req && $past(mem_req) |-> mem_addr == $past(mem_addr) + WORD_STEP;
  endproperty
  a_step: assert property (p_step) else $error("address step not one word"); // [RULE_25]

endmodule

// >>> shared/lsm_pkg.sv
package lsm_pkg;

  // ********************************************************************
  // Widths and fixed values
  // ********************************************************************
  localparam int          REG_COUNT       = 16;
  localparam int          IDX_W           = 4;
  localparam int          DATA_W          = 32;
  localparam int          CNT_W           = 5;
  localparam int          FIFO_DEPTH      = 8;
  localparam int          ENTRY_W         = IDX_W + DATA_W;
  localparam logic [3:0]  PC_IDX          = 4'hf;
  localparam logic [31:0] WORD_STEP       = 32'h0000_0004;
  localparam logic [31:0] PC_STORE_OFFSET = 32'h0000_000c;
  localparam logic [1:0]  ALIGN_MASK      = 2'h3;

  // ********************************************************************
  // Cycle positions inside one instruction
  // ********************************************************************
  localparam logic [1:0]  CYC_FIRST       = 2'h1;
  localparam logic [1:0]  CYC_SAT         = 2'h2;
  localparam logic [1:0]  TAIL_LEN_SHORT  = 2'h1;
  localparam logic [1:0]  TAIL_LEN_PC     = 2'h3;

  // ********************************************************************
  // Enumerations
  // ********************************************************************
  typedef enum logic [1:0] {
    CYC_IDLE = 2'b00,
    CYC_N    = 2'b01,
    CYC_S    = 2'b10,
    CYC_I    = 2'b11
  } cycle_kind_t;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_XFER     = 3'b001,
    ST_INTERNAL = 3'b010,
    ST_TAIL     = 3'b011,
    ST_DRAIN    = 3'b100
  } phase_t;

endpackage

// >>> src/lsm_fifo.sv
`timescale 1ns/1ps
module lsm_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 8,
  parameter int PTR_W = $clog2(DEPTH),
  parameter int CNT_W = $clog2(DEPTH + 1)
) (
  input  wire logic             mclk,
  input  wire logic             reset,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic [CNT_W-1:0]      count
);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0]            wr_ptr;
    logic [PTR_W-1:0]            rd_ptr;
    logic [CNT_W-1:0]            cnt;
  } fifo_state_t;

  fifo_state_t q;
  fifo_state_t n;
  logic        do_push;
  logic        do_pop;

  function automatic logic [PTR_W-1:0] next_ptr(input logic [PTR_W-1:0] p);
    if (p == PTR_W'(DEPTH - 1)) begin
      return '0;
    end
    return p + PTR_W'(1);
  endfunction

  assign in_ready  = (q.cnt != CNT_W'(DEPTH));
  assign out_valid = (q.cnt != '0);
  assign out_data  = q.mem[q.rd_ptr];
  assign count     = q.cnt;
  assign do_push   = in_valid && in_ready;
  assign do_pop    = out_valid && out_ready;

  always_comb begin
    n = q;
    if (do_push) begin
      n.mem[q.wr_ptr] = in_data;
      n.wr_ptr        = next_ptr(q.wr_ptr);
    end
    if (do_pop) begin
      n.rd_ptr = next_ptr(q.rd_ptr);
    end
    n.cnt = q.cnt + CNT_W'(do_push) - CNT_W'(do_pop);
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  property p_fifo_count;
    @(posedge mclk) disable iff (reset)
      do_push && !do_pop |=> count == $past(count) + CNT_W'(1);
  endproperty
  a_fifo_count: assert property (p_fifo_count) else $error("fifo count did not grow");

endmodule

// >>> bench/mem_model.sv
`timescale 1ns/1ps
module mem_model (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        mem_req,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] fault_addr,
  output logic [31:0]      mem_rdata,
  output logic             memory_fault_flag
);
  logic        ph_q;
  logic [31:0] a_q;
  always_ff @(posedge mclk) begin
    ph_q <= mem_req && !reset;
    a_q  <= mem_addr;
  end
  assign memory_fault_flag = ph_q && a_q == fault_addr;
  // Writes never land
  // Released bus shows the inverse of the last word
  assign mem_rdata = ph_q ? a_q ^ 32'h5a5a_0000 : ~(a_q ^ 32'h5a5a_0000);
endmodule

// >>> bench/tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fails++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module tb;
  import lsm_pkg::*;
  localparam logic [31:0] B0  = 32'h0000_1001;
  localparam logic [31:0] KEY = 32'h5a5a_0000;
  logic        mclk = 0, reset = 1, start = 0, is_load = 0, pre_index = 0, up_dir = 0;
  logic        user_bank_flag = 0, writeback_flag = 0, reg_wr_ready = 1, wph = 0;
  logic [3:0]  base_idx = '0;
  logic [15:0] reg_list = 16'h0001;
  logic [31:0] base_value = '0, instr_addr = 32'h0000_2000, fault_addr = '1;
  logic [31:0] rd_data, mem_rdata, mem_addr, mem_wdata, base_wr_data, reg_wr_data;
  logic [3:0]  rd_idx, base_wr_idx, reg_wr_idx;
  logic        busy, mem_req, mem_write, rd_user, base_wr, reg_wr_valid, reg_wr_user;
  logic        status_restore, data_abort, memory_fault_flag;
  cycle_kind_t cycle_kind;
  logic [31:0] aq[$], wq[$], dq[$], bwd;
  logic [3:0]  iq[$];
  int          nk, sk, ik, nab, nsr, nbw, nus, fails = 0, check_count = 0, t = 0;

  block_transfer_load_store_unit block_transfer_load_store_unit_inst (.*);
  mem_model mem_model_inst (.*);

  always #20 mclk = ~mclk;
  assign rd_data = (rd_idx == base_idx && !rd_user) ? base_value : {15'h0, rd_user, 12'h0, rd_idx};

  // ************************************
  // Monitor
  // ************************************
  always @(posedge mclk) begin
    wph <= mem_req && mem_write;
    if (wph) wq.push_back(mem_wdata);
    if (mem_req) aq.push_back(mem_addr);
    nk += (cycle_kind == CYC_N);
    sk += (cycle_kind == CYC_S);
    ik += (cycle_kind == CYC_I);
    nab += data_abort;
    if (base_wr) begin
      nbw++;
      bwd = base_wr_data;
    end
    if (reg_wr_valid && reg_wr_ready) begin
      iq.push_back(reg_wr_idx);
      dq.push_back(reg_wr_data);
      nsr += status_restore;
      nus += reg_wr_user;
    end
  end

  function automatic logic [31:0] rv(logic u, logic [3:0] i);
    return {15'h0, u, 12'h0, i};
  endfunction

  function automatic logic [31:0] lo(logic p, logic u, logic [31:0] bv, int n);
    return u ? bv + (p ? 4 : 0) : bv - 4 * n + (p ? 0 : 4);
  endfunction

  task automatic run(input logic l, p, u, s, w, input logic [3:0] b,
                     input logic [15:0] lst, input logic [31:0] bv, input int stall);
    aq = {};
    wq = {};
    iq = {};
    dq = {};
    {nk, sk, ik, nab, nsr, nbw, nus} = '0;
    @(posedge mclk);
    start <= 1;
    is_load <= l;
    pre_index <= p;
    up_dir <= u;
    user_bank_flag <= s;
    writeback_flag <= w;
    base_idx <= b;
    reg_list <= lst;
    base_value <= bv;
    reg_wr_ready <= (stall == 0);
    @(posedge mclk) start <= 0;
    repeat (stall) @(posedge mclk);
    reg_wr_ready <= 1;
    #1;
    for (int k = 0; k < 300 && busy !== 1'b0; k++) @(posedge mclk);
    if (busy !== 1'b0) fails++;
    repeat (3) @(posedge mclk);
    t++;
    $display("test %0d done", t);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    #400000;
    fails++;
    tally_and_finish;
  end

  initial begin
    repeat (4) @(posedge mclk);
    reset <= 0;
    for (int m = 0; m < 4; m++) begin
      run(0, m[1], m[0], 0, 1, 4'h3, 16'h0006, B0, 0);
      `CHK("addr0", lo(m[1], m[0], B0, 2), aq[0])
      `CHK("addr1", lo(m[1], m[0], B0, 2) + 4, aq[1])
      `CHK("wdata0", rv(0, 1), wq[0])
      `CHK("wb", m[0] ? B0 + 8 : B0 - 8, bwd)
      `CHK("wbcnt", 1, nbw)
      `CHK("ncyc", 2, nk)
      `CHK("scyc", 1, sk)
    end
    for (int b = 0; b < 4; b += 2) begin
      run(0, 0, 1, 0, 1, b[3:0], 16'h8005, B0, 0);
      `CHK("basest", b == 0 ? B0 : B0 + 12, wq[b / 2])
      `CHK("pcst", 32'h0000_200c, wq[2])
    end
    for (int c = 0; c < 2; c++) begin
      run(0, 1, 0, 1, 0, 4'h1, c ? 16'hc000 : 16'h6000, B0, 0);
      `CHK("usrst", rv(1, c ? 4'he : 4'hd), wq[0])
    end
    run(1, 1, 0, 1, 1, 4'h3, 16'h8009, B0, 0);
    `CHK("ldcnt", 3, iq.size())
    `CHK("ldbase", (B0 - 8) ^ KEY, dq[1])
    `CHK("ldpc", 4'hf, iq[2])
    `CHK("restore", 1, nsr)
    `CHK("ldn", 2, nk)
    `CHK("lds", 4, sk)
    `CHK("ldi", 1, ik)
    fault_addr <= B0 + 8;
    run(1, 0, 1, 0, 1, 4'h2, 16'h0016, B0, 3);
    `CHK("abwr", 3, iq.size())
    `CHK("abidx", 4'h2, iq[2])
    `CHK("abbase", B0 + 12, dq[2])
    `CHK("abtrap", 1, nab)
    fault_addr <= B0;
    run(0, 0, 1, 0, 0, 4'h5, 16'h0007, B0, 0);
    `CHK("staddr", 3, aq.size())
    `CHK("sttrap", 1, nab)
    `CHK("stwb", 0, nbw)
    fault_addr <= '1;
    run(1, 0, 1, 1, 0, 4'hd, 16'h0fff, B0, 20);
    `CHK("bufcnt", 12, iq.size())
    `CHK("buflast", 4'hb, iq[11])
    `CHK("bufusr", 12, nus)
    `CHK("bufns", 13, nk + sk)
    tally_and_finish;
  end
endmodule
